/* File: adcc_top.sv */
// converter control, clocking and result registers behind apb
//
// How it works
// - done flag sets per conversion when irq off
// - control writes or low read clear flag
// - irq on: flag reads zero, irq raised
// - low result read or status write drops irq
// - continuous bit repeats conversions, else one
// - channel codes pick pins, ones power off
// - prescaler divides by 1,2,4,8,16
// - source bit picks bus or crystal
// - two-bit field picks justification, right default
// - truncated: low byte bits 9-2, no lock
// - right: two msbs high, eight low
// - left: eight msbs high, two low
// - signed left inverts result msb
// - high read locks, results dropped till low
// - control writes or reset release lock
// - status write starts aligned conversion unless it writes the power-off channel code
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [adcc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          crystal_clock,
	output logic                               conv_tick,
	output logic                               conv_start,
	output logic      [7:0]                    analog_pin_select,
	output logic                               converter_power_down,
	input  wire logic                          conv_done,
	input  wire logic [9:0]                    conv_result,
	output logic                               conv_irq
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [4:0]            channel_select_field_ff;
	logic                  continuous_convert_bit_ff;
	logic                  completion_irq_enable_ff;
	logic                  conversion_done_flag_ff;
	logic                  irq_pending_ff;
	logic [2:0]            clock_divider_field_ff;
	logic                  clock_source_select_ff;
	logic [1:0]            justify_ff;
	logic [2:0]            scan_ff;
	logic [7:0]            result_high_byte_ff;
	logic [7:0]            result_low_byte_ff;
	logic                  lock_ff;
	logic                  start_ff;
	logic [31:0]           prdata_ff;
	adcc_pkg::adcc_state_t state_ff;
	adcc_pkg::adcc_state_t nxt_state;

	// ************************************************************
	// apb decode
	// ************************************************************
	wire logic [9:0]  word_idx;
	wire logic        setup_ph;
	wire logic        access_ph;
	wire logic        hit_sc;
	wire logic        hit_cf;
	wire logic        hit_rh;
	wire logic        hit_rl;
	wire logic        hit_scan;
	wire logic        mapped;
	wire logic        wr_sc;
	wire logic        wr_cf;
	wire logic        wr_scan;
	wire logic        rd_rh;
	wire logic        rd_rl;
	wire logic [7:0]  wb;
	wire logic [7:0]  rd_byte;
	wire logic [7:0]  sc_view;
	wire logic [7:0]  cf_view;
	wire logic [7:0]  rh_view;

	assign word_idx  = paddr[adcc_pkg::ADDR_W-1:2];
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign hit_sc    = word_idx == {2'h0, adcc_pkg::IDX_STATUS_CTRL};
	assign hit_cf    = word_idx == {2'h0, adcc_pkg::IDX_CLOCK_FMT};
	assign hit_rh    = word_idx == {2'h0, adcc_pkg::IDX_RESULT_HI};
	assign hit_rl    = word_idx == {2'h0, adcc_pkg::IDX_RESULT_LO};
	assign hit_scan  = word_idx == {2'h0, adcc_pkg::IDX_SCAN_CTRL};
	assign mapped    = (hit_sc | hit_cf | hit_rh | hit_rl | hit_scan)
		& (paddr[1:0] == 2'h0);
	assign wr_sc     = access_ph & pwrite & mapped & hit_sc;
	assign wr_cf     = access_ph & pwrite & mapped & hit_cf;
	assign wr_scan   = access_ph & pwrite & mapped & hit_scan;
	assign rd_rh     = access_ph & ~pwrite & mapped & hit_rh;
	assign rd_rl     = access_ph & ~pwrite & mapped & hit_rl;
	assign wb        = pwdata[7:0];

	assign pready    = access_ph;
	assign pslverr   = access_ph & ~mapped;
	assign prdata    = prdata_ff;

	// status view: done flag hidden while irq enabled
	assign sc_view = {conversion_done_flag_ff & ~completion_irq_enable_ff,
		completion_irq_enable_ff, continuous_convert_bit_ff,
		channel_select_field_ff};
	assign cf_view = {clock_divider_field_ff, clock_source_select_ff,
		justify_ff, 2'h0};
	// high byte reads zero while truncated mode is selected
	assign rh_view = (justify_ff == adcc_pkg::MODE_TRUNC8) ? 8'h00
		: result_high_byte_ff;

	assign rd_byte = ~mapped ? 8'h00 :
		hit_sc ? sc_view :
		hit_cf ? cf_view :
		hit_rh ? rh_view :
		hit_rl ? result_low_byte_ff :
		{5'h00, scan_ff};

	// ************************************************************
	// converter clock and channel
	// ************************************************************
	wire logic       powered_off;
	wire logic [7:0] pin_onehot;

	adcc_clk_div u_clk_div (
		.clk                 (clk),
		.reset               (reset),
		.crystal_clock       (crystal_clock),
		.clock_source_select (clock_source_select_ff),
		.clock_divider_field (clock_divider_field_ff),
		.conv_tick           (conv_tick)
	);

	assign powered_off = channel_select_field_ff == adcc_pkg::CHAN_POWER_OFF;
	assign pin_onehot  = 8'h01 << channel_select_field_ff[2:0];
	assign analog_pin_select = (channel_select_field_ff
		<= adcc_pkg::CHAN_LAST_PIN) ? pin_onehot : 8'h00;
	assign converter_power_down = powered_off;

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	wire logic again;
	assign again = conv_done & continuous_convert_bit_ff & ~powered_off;
	assign conv_start = start_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			adcc_pkg::ADCC_IDLE: begin
				if (wr_sc & (wb[4:0] != adcc_pkg::CHAN_POWER_OFF))
					nxt_state = adcc_pkg::ADCC_ALIGN;
			end
			adcc_pkg::ADCC_ALIGN: begin
				if (powered_off)
					nxt_state = adcc_pkg::ADCC_IDLE;
				else if (conv_tick)
					nxt_state = adcc_pkg::ADCC_BUSY;
			end
			adcc_pkg::ADCC_BUSY: begin
				if (wr_sc)
					nxt_state = adcc_pkg::ADCC_ALIGN;
				else if (powered_off)
					nxt_state = adcc_pkg::ADCC_IDLE;
				else if (conv_done)
					nxt_state = again ? adcc_pkg::ADCC_ALIGN
						: adcc_pkg::ADCC_IDLE;
			end
			default: nxt_state = adcc_pkg::ADCC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= adcc_pkg::ADCC_IDLE;
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= (state_ff == adcc_pkg::ADCC_ALIGN) & conv_tick
				& ~powered_off;
		end
	end

	// ************************************************************
	// result capture and interlock
	// ************************************************************
	wire logic [7:0] fmt_hi;
	wire logic [7:0] fmt_lo;
	wire logic       is_trunc;
	wire logic       take_result;
	wire logic       lock_clear;

	adcc_fmt u_fmt (
		.justify_mode (justify_ff),
		.result       (conv_result),
		.hi_byte      (fmt_hi),
		.lo_byte      (fmt_lo)
	);

	assign is_trunc    = justify_ff == adcc_pkg::MODE_TRUNC8;
	assign take_result = conv_done & (state_ff == adcc_pkg::ADCC_BUSY)
		& (~lock_ff | is_trunc);
	assign lock_clear  = rd_rl | wr_sc | wr_cf;

	always_ff @(posedge clk) begin
		if (reset) begin
			result_high_byte_ff <= adcc_pkg::RESULT_RESET;
			result_low_byte_ff  <= adcc_pkg::RESULT_RESET;
			lock_ff             <= 1'b0;
		end else begin
			if (take_result) begin
				result_high_byte_ff <= fmt_hi;
				result_low_byte_ff  <= fmt_lo;
			end
			if (lock_clear)
				lock_ff <= 1'b0;
			else if (rd_rh & ~is_trunc)
				lock_ff <= 1'b1;
		end
	end

	// ************************************************************
	// done flag and interrupt
	// ************************************************************
	wire logic done_evt;
	assign done_evt = conv_done & (state_ff == adcc_pkg::ADCC_BUSY);
	assign conv_irq = irq_pending_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			conversion_done_flag_ff <= 1'b0;
			irq_pending_ff          <= 1'b0;
		end else begin
			if (done_evt & ~completion_irq_enable_ff)
				conversion_done_flag_ff <= 1'b1;
			else if (wr_sc | wr_cf | rd_rl | completion_irq_enable_ff)
				conversion_done_flag_ff <= 1'b0;
			if (done_evt & completion_irq_enable_ff)
				irq_pending_ff <= 1'b1;
			else if (rd_rl | wr_sc | ~completion_irq_enable_ff)
				irq_pending_ff <= 1'b0;
		end
	end

	// ************************************************************
	// control registers and read data
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			channel_select_field_ff   <= adcc_pkg::CHAN_RESET;
			continuous_convert_bit_ff <= 1'b0;
			completion_irq_enable_ff  <= 1'b0;
			clock_divider_field_ff    <= adcc_pkg::DIV_RESET;
			clock_source_select_ff    <= adcc_pkg::SRC_RESET;
			justify_ff                <= adcc_pkg::MODE_RESET;
			scan_ff                   <= 3'h0;
			prdata_ff                 <= 32'h0000_0000;
		end else begin
			if (wr_sc) begin
				completion_irq_enable_ff  <= wb[adcc_pkg::SC_IRQEN_BIT];
				continuous_convert_bit_ff <= wb[adcc_pkg::SC_CONT_BIT];
				channel_select_field_ff   <=
					wb[adcc_pkg::SC_CHAN_LSB +: 5];
			end
			if (wr_cf) begin
				clock_divider_field_ff <= wb[adcc_pkg::CF_DIV_LSB +: 3];
				clock_source_select_ff <= wb[adcc_pkg::CF_SRC_BIT];
				justify_ff <= wb[adcc_pkg::CF_MODE_LSB +: 2];
			end
			if (wr_scan)
				scan_ff <= wb[adcc_pkg::SCAN_CNT_LSB +: 3];
			if (setup_ph & ~pwrite)
				prdata_ff <= {24'h00_0000, rd_byte};
		end
	end
endmodule : adcc_top
`default_nettype wire

/* File: adcc_pkg.sv */
// shared constants and types for the converter control block
package adcc_pkg;
	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0]  IDX_STATUS_CTRL = 8'h57;
	localparam logic [7:0]  IDX_CLOCK_FMT   = 8'h58;
	localparam logic [7:0]  IDX_RESULT_HI   = 8'h59;
	localparam logic [7:0]  IDX_RESULT_LO   = 8'h5A;
	localparam logic [7:0]  IDX_SCAN_CTRL   = 8'h5E;
	localparam int          ADDR_W          = 12;
	// ************************************************************
	// status/control field positions
	// ************************************************************
	localparam int          SC_DONE_BIT     = 7;
	localparam int          SC_IRQEN_BIT    = 6;
	localparam int          SC_CONT_BIT     = 5;
	localparam int          SC_CHAN_LSB     = 0;
	localparam logic [4:0]  CHAN_RESET      = 5'h1F;
	localparam logic [4:0]  CHAN_POWER_OFF  = 5'h1F;
	localparam logic [4:0]  CHAN_LAST_PIN   = 5'h07;
	// ************************************************************
	// clock/format field positions
	// ************************************************************
	localparam int          CF_DIV_LSB      = 5;
	localparam int          CF_SRC_BIT      = 4;
	localparam int          CF_MODE_LSB     = 2;
	localparam logic [2:0]  DIV_RESET       = 3'h0;
	localparam logic        SRC_RESET       = 1'b0;
	// ************************************************************
	// scan control field positions
	// ************************************************************
	localparam int          SCAN_EN_BIT     = 2;
	localparam int          SCAN_CNT_LSB    = 0;
	// ************************************************************
	// justification modes
	// ************************************************************
	localparam logic [1:0]  MODE_TRUNC8     = 2'h0;
	localparam logic [1:0]  MODE_RIGHT      = 2'h1;
	localparam logic [1:0]  MODE_LEFT       = 2'h2;
	localparam logic [1:0]  MODE_LEFT_SIGN  = 2'h3;
	localparam logic [1:0]  MODE_RESET      = MODE_RIGHT;
	localparam logic [7:0]  RESULT_RESET    = 8'h00;
	// ************************************************************
	// conversion sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		ADCC_IDLE  = 2'b00,
		ADCC_ALIGN = 2'b01,
		ADCC_BUSY  = 2'b11
	} adcc_state_t;
endpackage : adcc_pkg

/* File: adcc_clk_div.sv */
// converter clock tick generator with source select and prescaler
`timescale 1ns/1ps
`default_nettype none
module adcc_clk_div (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       crystal_clock,
	input  wire logic       clock_source_select,
	input  wire logic [2:0] clock_divider_field,
	output logic            conv_tick
);
	// ************************************************************
	// prescaler decode
	// ************************************************************
	function automatic logic [3:0] div_last(input logic [2:0] code);
		logic [3:0] r;
		r = 4'hF;
		if (code == 3'h0) r = 4'h0;
		else if (code == 3'h1) r = 4'h1;
		else if (code == 3'h2) r = 4'h3;
		else if (code == 3'h3) r = 4'h7;
		return r;
	endfunction : div_last

	logic [1:0] xsync_ff;
	logic       xprev_ff;
	logic [3:0] cnt_ff;
	logic       tick_ff;
	wire logic  xtal_rise;
	wire logic  in_tick;
	wire logic  at_last;
	wire logic [3:0] nxt_cnt;
	wire logic [3:0] last;

	// ************************************************************
	// input clock edge and divide
	// ************************************************************
	assign xtal_rise = xsync_ff[1] & ~xprev_ff;
	assign in_tick   = clock_source_select ? 1'b1 : xtal_rise;
	assign last      = div_last(clock_divider_field);
	assign at_last   = cnt_ff >= last;
	assign nxt_cnt   = at_last ? 4'h0 : cnt_ff + 4'h1;
	assign conv_tick = tick_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			xsync_ff <= 2'h0;
			xprev_ff <= 1'b0;
			cnt_ff   <= 4'h0;
			tick_ff  <= 1'b0;
		end else begin
			xsync_ff <= {xsync_ff[0], crystal_clock};
			xprev_ff <= xsync_ff[1];
			tick_ff  <= in_tick & at_last;
			if (in_tick)
				cnt_ff <= nxt_cnt;
		end
	end
endmodule : adcc_clk_div
`default_nettype wire

/* File: adcc_fmt.sv */
// result justification into high and low bytes
`timescale 1ns/1ps
`default_nettype none
module adcc_fmt (
	input  wire logic [1:0] justify_mode,
	input  wire logic [9:0] result,
	output logic      [7:0] hi_byte,
	output logic      [7:0] lo_byte
);
	// ************************************************************
	// placement per mode
	// ************************************************************
	wire logic is_trunc;
	wire logic is_right;
	wire logic is_sign;
	assign is_trunc = justify_mode == adcc_pkg::MODE_TRUNC8;
	assign is_right = justify_mode == adcc_pkg::MODE_RIGHT;
	assign is_sign  = justify_mode == adcc_pkg::MODE_LEFT_SIGN;

	assign hi_byte = is_trunc ? 8'h00 :
		is_right ? {6'h00, result[9:8]} :
		{result[9] ^ is_sign, result[8:2]};
	assign lo_byte = is_trunc ? result[9:2] :
		is_right ? result[7:0] :
		{result[1:0], 6'h00};
endmodule : adcc_fmt
`default_nettype wire

/* File: adcc_top_sva.sv */
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_top_sva (
	input wire logic                        clk,
	input wire logic                        reset,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [adcc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        crystal_clock,
	input wire logic                        conv_tick,
	input wire logic                        conv_start,
	input wire logic [7:0]                  analog_pin_select,
	input wire logic                        converter_power_down,
	input wire logic                        conv_done,
	input wire logic [9:0]                  conv_result,
	input wire logic                        conv_irq
);
	// ****
	// access decode and checks
	// ****
	wire [9:0] idx_w = paddr[11:2];
	wire       acc_w = psel && penable;
	wire       st_w  = idx_w == {2'h0, adcc_pkg::IDX_STATUS_CTRL};
	wire       res_w = idx_w == {2'h0, adcc_pkg::IDX_RESULT_HI} ||
		idx_w == {2'h0, adcc_pkg::IDX_RESULT_LO};
	wire       drop_w = acc_w && ((pwrite && st_w) || (!pwrite && res_w));
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_start_after_tick: assert property (conv_start |-> $past(conv_tick))
		else $error("start without a preceding tick");
	a_start_one_cycle: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_pins_onehot: assert property ($onehot0(analog_pin_select))
		else $error("more than one pin selected");
	a_off_no_pins: assert property (converter_power_down |-> !analog_pin_select)
		else $error("pin selected while powered off");
	a_off_no_start: assert property
		(converter_power_down && $past(converter_power_down) |-> !conv_start)
		else $error("start while powered off");
	a_irq_needs_done: assert property ($rose(conv_irq) |-> $past(conv_done))
		else $error("interrupt without a finished conversion");
	a_irq_drop_cause: assert property
		($fell(conv_irq) && !$past(reset) |-> $past(drop_w))
		else $error("interrupt dropped without cause");
	a_reset_idle_out: assert property ($fell(reset) |-> !conv_irq &&
		converter_power_down && analog_pin_select == 8'h00 && !conv_start)
		else $error("outputs not idle after reset");
	a_zero_wait: assert property (acc_w |-> pready ##1 !pready)
		else $error("access phase not answered at once");
	c_irq: cover property ($rose(conv_irq));
	c_start: cover property (conv_start);
	c_refused: cover property (acc_w && pslverr);
endmodule : adcc_top_sva
bind adcc_top adcc_top_sva i_adcc_top_sva (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.crystal_clock(crystal_clock), .conv_tick(conv_tick),
	.conv_start(conv_start), .analog_pin_select(analog_pin_select),
	.converter_power_down(converter_power_down), .conv_done(conv_done),
	.conv_result(conv_result), .conv_irq(conv_irq));
`default_nettype wire

/* File: adcc_core_model.sv */
// behavioural analog core answering a start with a result
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model #(
	parameter int LAT = 4
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       conv_tick,
	input  wire logic       conv_start,
	input  wire logic [9:0] next_value,
	output logic            conv_done,
	output logic      [9:0] conv_result
);
	// ****
	// result a fixed number of ticks after start
	// ****
	logic [3:0] cnt_ff;
	wire        fin_w = conv_tick && cnt_ff == 4'h1 && !conv_start;
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_ff      <= 4'h0;
			conv_done   <= 1'b0;
			conv_result <= 10'h155;
		end else begin
			conv_done   <= fin_w;
			conv_result <= fin_w ? next_value : ~conv_result;
			if (conv_start)
				cnt_ff <= 4'(LAT);
			else if (conv_tick && cnt_ff != 4'h0)
				cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule : adcc_core_model
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin \
	n_mismatch++; $display("Error %s exp %h seen %h", n, e, g); end end
module tb;
	// ****
	// signals and helpers
	// ****
	localparam logic [7:0] A_SC = adcc_pkg::IDX_STATUS_CTRL;
	localparam logic [7:0] A_CF = adcc_pkg::IDX_CLOCK_FMT;
	localparam logic [7:0] A_HI = adcc_pkg::IDX_RESULT_HI;
	localparam logic [7:0] A_LO = adcc_pkg::IDX_RESULT_LO;
	logic        clk, reset, psel, penable, pwrite, crystal_clock;
	logic        pready, pslverr, conv_tick, conv_start, pdown, conv_done;
	logic        conv_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  pins;
	logic [9:0]  conv_result, nv, v, got_n, exp_n;
	logic [2:0]  xcnt;
	logic [31:0] lfsr_v;
	logic [15:0] f;
	logic [9:0]  note_q[$];
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cnt;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
		case (m)
			2'h0: fmt = {8'h00, r[9:2]};
			2'h1: fmt = {6'h00, r};
			2'h2: fmt = {r, 6'h00};
			default: fmt = {~r[9], r[8:0], 6'h00};
		endcase
	endfunction : fmt
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [9:0] e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= {24'h0, d};
		note_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (conv_done !== 1'b1 && n < 600);
		`CHK("conversion done", n < 600, 1'b1)
		repeat (3) @(posedge clk);
	endtask : wait_done
	task automatic conv(input logic [7:0] sc, input logic [9:0] val);
		nv <= val;
		apb(1'b1, A_SC, sc, 10'h000);
		wait_done();
	endtask : conv
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	adcc_top i_adcc_top (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_clock(crystal_clock), .conv_tick(conv_tick),
		.conv_start(conv_start), .analog_pin_select(pins),
		.converter_power_down(pdown), .conv_done(conv_done),
		.conv_result(conv_result), .conv_irq(conv_irq));
	adcc_core_model i_adcc_core_model (.clk(clk), .reset(reset),
		.conv_tick(conv_tick), .conv_start(conv_start), .next_value(nv),
		.conv_done(conv_done), .conv_result(conv_result));
	// ****
	// clocks, monitor and watchdog
	// ****
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		xcnt <= xcnt + 3'h1;
		crystal_clock <= xcnt[2];
	end
	always @(posedge clk) begin
		if (psel && penable && pready) begin
			exp_n = note_q.pop_front();
			got_n = {pslverr, conv_irq, pwrite ? 8'h00 : prdata[7:0]};
			`CHK("apb access", exp_n, got_n)
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
	// ****
	// scenarios
	// ****
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {3'h4, 45'h0};
		{nv, xcnt, crystal_clock, lfsr_v} = {14'h0, 32'hB729};
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, A_SC, 8'h00, 10'h01F);
		apb(1'b0, A_CF, 8'h00, 10'h004);
		apb(1'b1, A_HI, 8'hFF, 10'h000);
		apb(1'b0, A_HI, 8'h00, 10'h000);
		apb(1'b0, A_LO, 8'h00, 10'h000);
		apb(1'b0, adcc_pkg::IDX_SCAN_CTRL, 8'h00, 10'h000);
		apb(1'b0, 8'h60, 8'h00, 10'h200);
		for (int d = 0; d < 9; d++) begin
			apb(1'b1, A_CF, (d < 8) ? {d[2:0], 5'h14} : 8'h04, 10'h000);
			repeat (40) @(posedge clk);
			cnt = 0;
			repeat (64) begin
				@(posedge clk);
				cnt += (conv_tick === 1'b1);
			end
			`CHK("tick count", cnt, (d > 7) ? 8 : 64 >> (d > 3 ? 4 : d))
		end
		for (int c = 0; c < 9; c++) begin
			apb(1'b1, A_SC, (c < 8) ? c[7:0] : 8'h1F, 10'h000);
			@(posedge clk);
			`CHK("pin select", pins, (c < 8) ? 8'h01 << c : 8'h00)
			`CHK("power down", pdown, c == 8)
		end
		apb(1'b1, A_CF, 8'h44, 10'h000);
		conv(8'h03, 10'h000);
		for (int m = 0; m < 4; m++) begin
			lfsr_v = lfsr(lfsr_v);
			v = lfsr_v[9:0];
			f = fmt(m[1:0], v);
			apb(1'b1, A_CF, {4'h4, m[1:0], 2'h0}, 10'h000);
			conv(8'h03, v);
			apb(1'b0, A_SC, 8'h00, 10'h083);
			apb(1'b0, A_HI, 8'h00, {2'h0, f[15:8]});
			apb(1'b0, A_LO, 8'h00, {2'h0, f[7:0]});
			apb(1'b0, A_SC, 8'h00, 10'h003);
		end
		conv(8'h03, 10'h111);
		apb(1'b1, A_CF, 8'h44, 10'h000);
		apb(1'b0, A_SC, 8'h00, 10'h003);
		conv(8'h03, 10'h2C7);
		apb(1'b0, A_HI, 8'h00, 10'h002);
		conv(8'h03, 10'h222);
		apb(1'b0, A_LO, 8'h00, 10'h022);
		conv(8'h23, 10'h2A5);
		apb(1'b0, A_HI, 8'h00, 10'h002);
		nv <= 10'h15A;
		wait_done();
		apb(1'b0, A_LO, 8'h00, 10'h0A5);
		wait_done();
		apb(1'b0, A_HI, 8'h00, 10'h001);
		apb(1'b0, A_LO, 8'h00, 10'h05A);
		nv <= 10'h3C9;
		apb(1'b1, A_CF, 8'h40, 10'h000);
		apb(1'b0, A_HI, 8'h00, 10'h000);
		wait_done();
		apb(1'b0, A_LO, 8'h00, 10'h0F2);
		apb(1'b1, A_CF, 8'h44, 10'h000);
		conv(8'h43, 10'h1E7);
		apb(1'b0, A_SC, 8'h00, 10'h143);
		apb(1'b0, A_LO, 8'h00, 10'h1E7);
		apb(1'b0, A_SC, 8'h00, 10'h043);
		conv(8'h43, 10'h0C3);
		apb(1'b1, A_SC, 8'h03, 10'h100);
		apb(1'b0, A_SC, 8'h00, 10'h003);
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, A_SC, 8'h00, 10'h01F);
		finish_test();
	end
endmodule : tb
`default_nettype wire
